/* verilog/sacu_top.sv */
// converter control unit: register front end, pin assignment and result handling
//
// Notes on behaviour
// - pin-select bit one makes pin analog
// - shared pin: interrupt, then analog, then port
// - reference from supply at zero, pin at one
// - rate codes divide by four, one, sixteen, two
// - run set by software, cleared only by hardware
// - power bit zero switches reference ladder off
// - channel code n routes channel n
// - calibration bit applies offset correction
// - polarity bit: zero negative, one positive
// - offset magnitude zero to seven LSB
// - calibration bit two reads zero
// - op-amp routing overrides channel field
// - op-amp source picks first or second output
// - completion loads result, clears run, sets flag
// - overhead three sys, 1.5, 4, 10 converter clocks
// - sleep completion wakes or shuts converter off
module sacu_top
  import sacu_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_wr,
  output logic [31:0] wb_dat_rd,
  output logic wb_ack,
  // pin assignment
  input wire logic ext_int_enable,
  output logic [7:0] pin_analog_enable,
  output logic pin0_int_owns,
  output logic pin0_analog_owns,
  output logic ref_from_pin,
  output logic reference_pin_is_port,
  // analog core
  input wire logic compare_high,
  output logic sample_hold,
  output logic [9:0] trial_code,
  output logic [2:0] channel_select,
  output logic opamp_route_enable,
  output logic opamp_source_select,
  output logic converter_enable,
  // system
  input wire logic sleep_mode,
  output logic wake_request,
  output logic conversion_done_flag,
  output logic conversion_irq_request,
  output logic conversion_run
);
  typedef struct packed {
    // software registers
    logic [7:0] pin_sel;
    logic ref_sel;
    logic [1:0] rate;
    logic run;
    logic power;
    logic [2:0] chan;
    logic cal_en;
    logic cal_sign;
    logic [2:0] cal_mag;
    logic route;
    logic source;
    logic [1:0] res_hi;
    logic [7:0] res_lo;
    logic done_flag;
    logic wake_en;
    logic irq_en;
    logic shutoff;
    // bus answer
    logic ack;
    logic [31:0] rdata;
    // converter handshake and registered outputs
    logic start;
    logic wake;
    logic pin0_int;
    logic pin0_analog;
    logic conv_en;
    logic irq_req;
    logic ref_port;
  } sacu_state_t;
  sacu_state_t r_reg, r_next;

  sacu_conv_if cv ();
  logic tick;
  logic restart;
  logic sample_int;
  logic [9:0] trial_int;
  logic req;
  logic wr;
  logic [7:0] wbyte;
  logic [9:0] adjusted;

  sacu_prescaler u_prescaler (
    .clock(clock),
    .srst(srst),
    .restart(restart),
    .rate(r_reg.rate),
    .tick(tick)
  );

  sacu_sequencer u_sequencer (
    .clock(clock),
    .srst(srst),
    .cv(cv),
    .tick(tick),
    .restart(restart),
    .compare_high(compare_high),
    .sample_hold(sample_int),
    .trial_code(trial_int)
  );

  assign cv.start = r_reg.start;
  assign cv.rate = r_reg.rate;

  // signed offset correction with saturation at both ends
  function automatic logic [9:0] apply_offset(
    input logic [9:0] raw,
    input logic en,
    input logic sign,
    input logic [2:0] mag
  );
    logic [10:0] sum;
    sum = {1'b0, raw};
    apply_offset = raw;
    if (en) begin
      if (sign) begin
        sum = {1'b0, raw} + {8'h00, mag};
        apply_offset = sum[10] ? RESULT_MAX : sum[9:0];
      end else begin
        apply_offset = (raw < {7'h00, mag}) ? 10'h000 : 10'(raw - {7'h00, mag});
      end
    end
  endfunction : apply_offset

  always_comb begin
    r_next = r_reg;
    req = wb_cyc && wb_stb && !r_reg.ack;
    wr = req && wb_we && wb_sel[0];
    wbyte = wb_dat_wr[7:0];
    adjusted = apply_offset(cv.raw, r_reg.cal_en, r_reg.cal_sign, r_reg.cal_mag);
    r_next.ack = req;
    r_next.start = 1'b0;
    r_next.wake = 1'b0;

    // register reads, captured with the answer
    r_next.rdata = 32'h0000_0000;
    if (req && !wb_we) begin
      unique case (wb_adr)
        ADDR_PIN_SELECT: r_next.rdata = {24'h00_0000, r_reg.pin_sel};
        ADDR_CONTROL: r_next.rdata = {24'h00_0000, r_reg.ref_sel, r_reg.rate,
          r_reg.run, r_reg.power, r_reg.chan};
        ADDR_CALIBRATION: r_next.rdata = {24'h00_0000, r_reg.cal_en, r_reg.cal_sign,
          r_reg.cal_mag, 1'b0, r_reg.route, r_reg.source};
        ADDR_RESULT_HIGH: r_next.rdata = {30'h0000_0000, r_reg.res_hi};
        ADDR_RESULT_LOW: r_next.rdata = {24'h00_0000, r_reg.res_lo};
        ADDR_STATUS: r_next.rdata = {27'h000_0000, r_reg.shutoff, cv.busy,
          r_reg.irq_en, r_reg.wake_en, r_reg.done_flag};
        default: r_next.rdata = 32'h0000_0000;
      endcase
    end

    // register writes, low byte lane only
    if (wr) begin
      unique case (wb_adr)
        ADDR_PIN_SELECT: r_next.pin_sel = wbyte;
        ADDR_CONTROL: begin
          r_next.ref_sel = wbyte[CTRL_REF_BIT];
          r_next.rate = wbyte[CTRL_RATE_LSB +: 2];
          r_next.power = wbyte[CTRL_POWER_BIT];
          r_next.chan = wbyte[CTRL_CHAN_LSB +: 3];
          // writing zero leaves the run bit alone
          if (wbyte[CTRL_RUN_BIT] && !r_reg.run && !cv.busy) begin
            r_next.run = 1'b1;
            r_next.start = 1'b1;
            r_next.shutoff = 1'b0;
          end
        end
        ADDR_CALIBRATION: begin
          r_next.cal_en = wbyte[CAL_ENABLE_BIT];
          r_next.cal_sign = wbyte[CAL_SIGN_BIT];
          r_next.cal_mag = wbyte[CAL_MAG_LSB +: 3];
          r_next.route = wbyte[CAL_ROUTE_BIT];
          r_next.source = wbyte[CAL_SOURCE_BIT];
        end
        ADDR_STATUS: begin
          r_next.wake_en = wbyte[STAT_WAKE_EN_BIT];
          r_next.irq_en = wbyte[STAT_IRQ_EN_BIT];
          if (wbyte[STAT_DONE_BIT]) r_next.done_flag = 1'b0;
        end
        default: ;
      endcase
    end

    // leaving sleep releases a converter shut off at completion
    if (!sleep_mode) r_next.shutoff = 1'b0;

    // completion comes after the clear so a new event is never lost
    if (cv.done) begin
      r_next.res_hi = adjusted[9:8];
      r_next.res_lo = adjusted[7:0];
      r_next.run = 1'b0;
      r_next.done_flag = 1'b1;
      if (sleep_mode) begin
        if (r_reg.wake_en) r_next.wake = 1'b1;
        else r_next.shutoff = 1'b1;
      end
    end

    // registered pin and core controls
    r_next.pin0_int = ext_int_enable;
    r_next.pin0_analog = r_next.pin_sel[0] && !ext_int_enable;
    r_next.conv_en = r_next.power && !r_next.shutoff;
    r_next.irq_req = r_next.done_flag && r_next.irq_en;
    r_next.ref_port = !r_next.ref_sel;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r_reg <= '0;
      r_reg.pin_sel <= PIN_SELECT_RESET;
      r_reg.ref_sel <= CONTROL_RESET[CTRL_REF_BIT];
      r_reg.ref_port <= !CONTROL_RESET[CTRL_REF_BIT];
      r_reg.rate <= CONTROL_RESET[CTRL_RATE_LSB +: 2];
      r_reg.power <= CONTROL_RESET[CTRL_POWER_BIT];
      r_reg.chan <= CONTROL_RESET[CTRL_CHAN_LSB +: 3];
      r_reg.cal_en <= CALIBRATION_RESET[CAL_ENABLE_BIT];
      r_reg.cal_sign <= CALIBRATION_RESET[CAL_SIGN_BIT];
      r_reg.cal_mag <= CALIBRATION_RESET[CAL_MAG_LSB +: 3];
      r_reg.route <= CALIBRATION_RESET[CAL_ROUTE_BIT];
      r_reg.source <= CALIBRATION_RESET[CAL_SOURCE_BIT];
      r_reg.wake_en <= STATUS_RESET[STAT_WAKE_EN_BIT];
      r_reg.irq_en <= STATUS_RESET[STAT_IRQ_EN_BIT];
    end else begin
      r_reg <= r_next;
    end
  end

  // bus answer
  assign wb_ack = r_reg.ack;
  assign wb_dat_rd = r_reg.rdata;

  // pin assignment
  assign pin_analog_enable = r_reg.pin_sel;
  assign pin0_int_owns = r_reg.pin0_int;
  assign pin0_analog_owns = r_reg.pin0_analog;
  assign ref_from_pin = r_reg.ref_sel;
  assign reference_pin_is_port = r_reg.ref_port;

  // analog core
  assign sample_hold = sample_int;
  assign trial_code = trial_int;
  assign channel_select = r_reg.chan;
  assign opamp_route_enable = r_reg.route;
  assign opamp_source_select = r_reg.source;
  assign converter_enable = r_reg.conv_en;

  // system
  assign wake_request = r_reg.wake;
  assign conversion_done_flag = r_reg.done_flag;
  assign conversion_irq_request = r_reg.irq_req;
  assign conversion_run = r_reg.run;
endmodule : sacu_top

/* verilog/sacu_pkg.sv */
// shared constants, register map and helpers for the converter control unit
package sacu_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN_SELECT = 8'h05;
  localparam logic [7:0] IDX_CONTROL = 8'h06;
  localparam logic [7:0] IDX_CALIBRATION = 8'h07;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h08;
  localparam logic [7:0] IDX_RESULT_LOW = 8'h09;
  localparam logic [7:0] IDX_STATUS = 8'h0A;
  localparam logic [7:0] ADDR_PIN_SELECT = 8'(IDX_PIN_SELECT * 4);
  localparam logic [7:0] ADDR_CONTROL = 8'(IDX_CONTROL * 4);
  localparam logic [7:0] ADDR_CALIBRATION = 8'(IDX_CALIBRATION * 4);
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'(IDX_RESULT_HIGH * 4);
  localparam logic [7:0] ADDR_RESULT_LOW = 8'(IDX_RESULT_LOW * 4);
  localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);
  // converter_control fields
  localparam int CTRL_REF_BIT = 7;
  localparam int CTRL_RATE_LSB = 5;
  localparam int CTRL_RUN_BIT = 4;
  localparam int CTRL_POWER_BIT = 3;
  localparam int CTRL_CHAN_LSB = 0;
  // offset_calibration fields
  localparam int CAL_ENABLE_BIT = 7;
  localparam int CAL_SIGN_BIT = 6;
  localparam int CAL_MAG_LSB = 3;
  localparam int CAL_ROUTE_BIT = 1;
  localparam int CAL_SOURCE_BIT = 0;
  // status fields
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_WAKE_EN_BIT = 1;
  localparam int STAT_IRQ_EN_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_SHUTOFF_BIT = 4;
  // values after reset
  localparam logic [7:0] PIN_SELECT_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CALIBRATION_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // conversion timing
  localparam logic [5:0] DGD_SYS_CYCLES = 6'h03;
  localparam logic [5:0] SAMPLE_CLOCKS = 6'h04;
  localparam logic [3:0] TOP_BIT = 4'h9;
  localparam logic [9:0] RESULT_MAX = 10'h3FF;

  // oscillator divide ratio per clock-rate code
  function automatic logic [4:0] rate_divisor(input logic [1:0] code);
    unique case (code)
      2'h0: rate_divisor = 5'h04;
      2'h1: rate_divisor = 5'h01;
      2'h2: rate_divisor = 5'h10;
      2'h3: rate_divisor = 5'h02;
    endcase
  endfunction : rate_divisor

  // 1.5 converter clocks in system cycles, rounded up
  function automatic logic [5:0] overhead_cycles(input logic [1:0] code);
    logic [6:0] d;
    d = {2'h0, rate_divisor(code)};
    overhead_cycles = 6'((7'h03 * d + 7'h01) >> 1);
  endfunction : overhead_cycles
endpackage : sacu_pkg

/* verilog/sacu_conv_if.sv */
// link between register front end and conversion sequencer
interface sacu_conv_if;
  logic start;
  logic [1:0] rate;
  logic busy;
  logic done;
  logic [9:0] raw;
  modport ctrl (output start, output rate, input busy, input done, input raw);
  modport seq (input start, input rate, output busy, output done, output raw);
endinterface : sacu_conv_if

/* verilog/sacu_prescaler.sv */
// oscillator prescaler giving one tick per converter clock
module sacu_prescaler
  import sacu_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // control
  input wire logic restart,
  input wire logic [1:0] rate,
  // converter clock tick
  output logic tick
);
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } sacu_presc_t;
  sacu_presc_t r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (restart || (r_reg.cnt + 5'h01 >= rate_divisor(rate))) begin
      r_next.cnt = 5'h00;
      r_next.tick = !restart;
    end else begin
      r_next.cnt = r_reg.cnt + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) r_reg <= '0;
    else r_reg <= r_next;
  end

  assign tick = r_reg.tick;
endmodule : sacu_prescaler

/* verilog/sacu_sequencer.sv */
// successive-approximation sequencer with digital overhead phases
module sacu_sequencer
  import sacu_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // front end
  sacu_conv_if.seq cv,
  // prescaler
  input wire logic tick,
  output logic restart,
  // analog core
  input wire logic compare_high,
  output logic sample_hold,
  output logic [9:0] trial_code
);
  typedef enum logic [2:0] {IDLE, DGD_SYS, DGD_CONV, SAMPLE, CONVERT} sacu_seq_state_t;
  typedef struct packed {
    sacu_seq_state_t state;
    logic [5:0] cnt;
    logic [3:0] bitpos;
    logic [9:0] code;
    logic busy;
    logic done;
    logic sample;
    logic restart;
  } sacu_seq_t;
  sacu_seq_t r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.restart = 1'b0;
    unique case (r_reg.state)
      IDLE: if (cv.start) begin
        r_next.state = DGD_SYS;
        r_next.cnt = 6'h00;
        r_next.busy = 1'b1;
      end
      DGD_SYS: begin
        r_next.cnt = r_reg.cnt + 6'h01;
        if (r_reg.cnt == DGD_SYS_CYCLES - 6'h01) begin
          r_next.state = DGD_CONV;
          r_next.cnt = 6'h00;
        end
      end
      DGD_CONV: begin
        r_next.cnt = r_reg.cnt + 6'h01;
        if (r_reg.cnt == overhead_cycles(cv.rate) - 6'h01) begin
          r_next.state = SAMPLE;
          r_next.cnt = 6'h00;
          r_next.restart = 1'b1;
          r_next.sample = 1'b1;
        end
      end
      SAMPLE: if (tick) begin
        r_next.cnt = r_reg.cnt + 6'h01;
        if (r_reg.cnt == SAMPLE_CLOCKS - 6'h01) begin
          r_next.state = CONVERT;
          r_next.sample = 1'b0;
          r_next.bitpos = TOP_BIT;
          r_next.code = 10'h200;
        end
      end
      CONVERT: if (tick) begin
        if (!compare_high) r_next.code[r_reg.bitpos] = 1'b0;
        if (r_reg.bitpos == 4'h0) begin
          r_next.state = IDLE;
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
        end else begin
          r_next.bitpos = r_reg.bitpos - 4'h1;
          r_next.code[4'(r_reg.bitpos - 4'h1)] = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) r_reg <= '0;
    else r_reg <= r_next;
  end

  assign cv.busy = r_reg.busy;
  assign cv.done = r_reg.done;
  assign cv.raw = r_reg.code;
  assign restart = r_reg.restart;
  assign sample_hold = r_reg.sample;
  assign trial_code = r_reg.code;
endmodule : sacu_sequencer

/* tb/sacu_top_asserts.sv */
// port-level checker for the converter control unit
module sacu_top_asserts
  import sacu_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // register bus
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_wr,
  input wire logic wb_ack,
  // pins
  input wire logic ext_int_enable,
  input wire logic pin0_int_owns,
  input wire logic pin0_analog_owns,
  input wire logic ref_from_pin,
  input wire logic reference_pin_is_port,
  // conversion
  input wire logic sample_hold,
  input wire logic wake_request,
  input wire logic conversion_done_flag,
  input wire logic conversion_irq_request,
  input wire logic conversion_run
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] run_cnt_reg;
  logic start_wr;
  assign start_wr = wb_cyc && wb_stb && !wb_ack && wb_we && wb_sel[0]
    && wb_adr == ADDR_CONTROL && wb_dat_wr[CTRL_RUN_BIT] && !conversion_run;
  // cycles spent with run set
  always_ff @(posedge clock) begin
    if (srst || !conversion_run) begin
      run_cnt_reg <= 9'h000;
    end else begin
      run_cnt_reg <= run_cnt_reg + 9'h001;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  chk_bus_ack_next: assert property ((wb_cyc && wb_stb && !wb_ack) |=> wb_ack)
    else $error("request not acknowledged next cycle");
  chk_ack_single: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  chk_int_owns_pin:
    assert property (!$past(srst) |-> pin0_int_owns == $past(ext_int_enable))
    else $error("interrupt ownership does not follow enable");
  chk_int_over_analog:
    assert property (pin0_int_owns |-> !pin0_analog_owns)
    else $error("analog owns pin while interrupt does");
  chk_ref_pin_port:
    assert property (reference_pin_is_port == !ref_from_pin)
    else $error("reference pin use inconsistent");
  chk_run_start:
    assert property (start_wr |=> conversion_run)
    else $error("run write did not start conversion");
  chk_flag_ends_run:
    assert property ($rose(conversion_done_flag) |-> $fell(conversion_run))
    else $error("flag set without run clearing");
  chk_run_hw_clear:
    assert property ($fell(conversion_run) |-> conversion_done_flag)
    else $error("run cleared without completion");
  chk_irq_needs_flag:
    assert property (conversion_irq_request |-> conversion_done_flag)
    else $error("irq request without flag");
  chk_sample_four:
    assert property ($rose(sample_hold) |-> sample_hold[*4])
    else $error("sampling shorter than four clocks");
  chk_conv_length:
    assert property ($fell(conversion_run) |->
      $past(run_cnt_reg) >= 9'h010 && $past(run_cnt_reg) <= 9'h104)
    else $error("conversion length out of range");
  chk_wake_pulse:
    assert property (wake_request |=> !wake_request)
    else $error("wake request longer than one cycle");
endmodule : sacu_top_asserts

bind sacu_top sacu_top_asserts sacu_top_asserts_inst (.clock(clock), .srst(srst),
  .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
  .wb_dat_wr(wb_dat_wr), .wb_ack(wb_ack), .ext_int_enable(ext_int_enable),
  .pin0_int_owns(pin0_int_owns), .pin0_analog_owns(pin0_analog_owns),
  .ref_from_pin(ref_from_pin), .reference_pin_is_port(reference_pin_is_port),
  .sample_hold(sample_hold), .wake_request(wake_request),
  .conversion_done_flag(conversion_done_flag),
  .conversion_irq_request(conversion_irq_request), .conversion_run(conversion_run));

/* tb/sacu_analog_model.sv */
// behavioural analog core: input multiplexer, sample capacitor, comparator
module sacu_analog_model (
  // clock
  input wire logic clock,
  // converter control
  input wire logic sample_hold,
  input wire logic [9:0] trial_code,
  input wire logic [2:0] channel_select,
  input wire logic opamp_route_enable,
  input wire logic opamp_source_select,
  input wire logic converter_enable,
  // comparator
  output logic compare_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] level;
  logic [9:0] held = 10'h000;
  logic toggle = 1'b0;
  // op-amp outputs sit near both rails
  always_comb begin
    if (opamp_route_enable) begin
      level = opamp_source_select ? 10'h3FC : 10'h002;
    end else begin
      level = {channel_select, 7'h15};
    end
  end
  always @(posedge clock) begin
    toggle <= !toggle;
    if (sample_hold) held <= level;
  end
  // unpowered comparator gives no usable answer
  assign compare_high = converter_enable ? (held >= trial_code) : toggle;
endmodule : sacu_analog_model

/* tb/sacu_top_bench.sv */
// self-checking bench for the converter control unit
module sacu_top_bench
  import sacu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, ext_int_enable = 1'b0, sleep_mode = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h1;
  logic [31:0] wb_dat_wr = 32'h0000_0000;
  logic [31:0] wb_dat_rd, rd;
  logic [9:0] trial_code;
  logic [7:0] pin_analog_enable;
  logic [7:0] stat = 8'h00;
  logic [2:0] channel_select;
  logic wb_ack, pin0_int_owns, pin0_analog_owns, ref_from_pin, reference_pin_is_port;
  logic compare_high, sample_hold, opamp_route_enable, opamp_source_select, converter_enable;
  logic wake_request, conversion_done_flag, conversion_irq_request, conversion_run;
  int miscompares = 0, n_compared = 0, wakes = 0, cyc = 0;
  logic [7:0] cal_tab [5] = '{8'hF8, 8'h98, 8'h78, 8'hBA, 8'hFB};
  logic [9:0] cal_exp [5] = '{10'h11C, 10'h112, 10'h115, 10'h000, 10'h3FF};

  sacu_top sacu_top_inst (.clock(clock), .srst(srst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr),
    .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack), .ext_int_enable(ext_int_enable),
    .pin_analog_enable(pin_analog_enable), .pin0_int_owns(pin0_int_owns),
    .pin0_analog_owns(pin0_analog_owns), .ref_from_pin(ref_from_pin),
    .reference_pin_is_port(reference_pin_is_port), .compare_high(compare_high),
    .sample_hold(sample_hold), .trial_code(trial_code), .channel_select(channel_select),
    .opamp_route_enable(opamp_route_enable), .opamp_source_select(opamp_source_select),
    .converter_enable(converter_enable), .sleep_mode(sleep_mode),
    .wake_request(wake_request), .conversion_done_flag(conversion_done_flag),
    .conversion_irq_request(conversion_irq_request), .conversion_run(conversion_run));
  sacu_analog_model sacu_analog_model_inst (.clock(clock), .sample_hold(sample_hold),
    .trial_code(trial_code), .channel_select(channel_select),
    .opamp_route_enable(opamp_route_enable), .opamp_source_select(opamp_source_select),
    .converter_enable(converter_enable), .compare_high(compare_high));

  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (wake_request === 1'b1) wakes <= wakes + 1;
  end

  task complete_run;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_wr <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_dat_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (wb_ack !== 1'b1) begin
      miscompares++;
      complete_run();
    end
  endtask : bus

  task conv(input logic [7:0] ctl, input logic [9:0] ev, input logic poke);
    int k, t0, d, dev;
    bus(1'b1, ADDR_CONTROL, ctl | 8'h08);
    repeat (8) @(posedge clock);
    bus(1'b1, ADDR_CONTROL, ctl | 8'h18);
    t0 = cyc;
    if (poke) begin
      bus(1'b1, ADDR_CONTROL, ctl | 8'h08);
      check(32'(conversion_run), 32'h1);
    end
    for (k = 0; k < 400 && conversion_run === 1'b1; k++) @(posedge clock);
    if (k == 400) begin
      miscompares++;
      complete_run();
    end
    d = ctl[6:5] == 2'h0 ? 4 : ctl[6:5] == 2'h1 ? 1 : ctl[6:5] == 2'h2 ? 16 : 2;
    // plus start, prescaler restart, tick and completion registers
    dev = cyc - t0 - (3 + (3 * d + 1) / 2 + 14 * d) - 4;
    check(32'(dev >= -3 && dev <= 3), 32'h1);
    check(32'(conversion_irq_request), 32'(stat[2]));
    bus(1'b0, ADDR_RESULT_HIGH, 8'h00);
    check(rd, 32'(ev[9:8]));
    bus(1'b0, ADDR_RESULT_LOW, 8'h00);
    check(rd, 32'(ev[7:0]));
    check(32'(conversion_done_flag), 32'h1);
    bus(1'b1, ADDR_STATUS, stat | 8'h01);
    repeat (40) @(posedge clock);
  endtask : conv

  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    check(32'(reference_pin_is_port), 32'h1);
    for (int a = 5; a < 11; a++) begin
      bus(1'b0, 8'(a * 4), 8'h00);
      check(rd, 32'h0000_0000);
    end
    bus(1'b1, ADDR_PIN_SELECT, 8'hA5);
    bus(1'b0, ADDR_PIN_SELECT, 8'h00);
    check(rd, 32'h0000_00A5);
    check(32'(pin_analog_enable), 32'h0000_00A5);
    check(32'(pin0_analog_owns), 32'h1);
    ext_int_enable <= 1'b1;
    repeat (2) @(posedge clock);
    check(32'({pin0_int_owns, pin0_analog_owns}), 32'h2);
    ext_int_enable <= 1'b0;
    wb_sel <= 4'h0;
    bus(1'b1, ADDR_PIN_SELECT, 8'h00);
    wb_sel <= 4'h1;
    bus(1'b0, ADDR_PIN_SELECT, 8'h00);
    check(rd, 32'h0000_00A5);
    bus(1'b1, 8'h3C, 8'hFF);
    bus(1'b0, 8'h3C, 8'h00);
    check(rd, 32'h0000_0000);
    bus(1'b1, ADDR_CALIBRATION, 8'hFF);
    bus(1'b0, ADDR_CALIBRATION, 8'h00);
    check(rd, 32'h0000_00FB);
    check(32'({opamp_route_enable, opamp_source_select}), 32'h3);
    bus(1'b1, ADDR_CONTROL, 8'h85);
    bus(1'b0, ADDR_CONTROL, 8'h00);
    check(rd, 32'h0000_0085);
    check(32'({ref_from_pin, reference_pin_is_port, converter_enable}), 32'h4);
    check(32'(channel_select), 32'h5);
    bus(1'b1, ADDR_CONTROL, 8'h08);
    repeat (2) @(posedge clock);
    check(32'({ref_from_pin, reference_pin_is_port, converter_enable}), 32'h3);
    bus(1'b1, ADDR_CALIBRATION, 8'h00);
    // every rate code and channel; rate code is the channel's low two bits
    for (int i = 0; i < 8; i++) conv({1'b0, 2'(i), 2'h0, 3'(i)}, {3'(i), 7'h15}, i == 2);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ADDR_CALIBRATION, cal_tab[i]);
      conv(8'h22, cal_exp[i], 1'b0);
    end
    bus(1'b1, ADDR_CALIBRATION, 8'h00);
    stat = 8'h02;
    bus(1'b1, ADDR_STATUS, stat);
    sleep_mode <= 1'b1;
    conv(8'h21, 10'h095, 1'b0);
    check(32'(wakes), 32'h1);
    stat = 8'h04;
    bus(1'b1, ADDR_STATUS, stat);
    conv(8'h21, 10'h095, 1'b0);
    check(32'({converter_enable, wakes[0]}), 32'h1);
    bus(1'b0, ADDR_STATUS, 8'h00);
    check(rd, 32'h0000_0014);
    sleep_mode <= 1'b0;
    repeat (2) @(posedge clock);
    check(32'(converter_enable), 32'h1);
    complete_run();
  end
endmodule : sacu_top_bench
